// ---- core/scg_sleep_ctrl.sv ----
// Sleep mode, wake source and per-peripheral clock gating controller.
// Assumes a CPU-side register port, a sleep instruction pulse and level inputs
// from the interrupt, converter, comparator, watchdog and brown-out blocks.
// Function
// - Mode field codes: idle 000, noise reduction 001, power-down 010, standby 110, rest reserved.
// - Mode 110 with crystal clock enters standby; main oscillator keeps running.
// - Standby wake resumes execution six clock cycles after the wake event.
// - Each sleep mode keeps its own set of clock domains; core clocks always stop.
// - Each sleep mode accepts only its own set of wake sources.
// - Outside idle, external lines wake only when set as level interrupts.
// - A set gate bit stops that clock, except a running timer's, and blocks its register access.
// - Clearing a gate bit restarts the clock with state preserved.
// - Peripheral gating acts in active, idle and, for the converter bit, noise reduction; deeper modes stop clocks anyway.
// - Gate register: bits 7..5 power stages, 4..3 timers, 2 SPI, 1 serial, 0 converter.
// - Gated timers keep running while the timer itself stays enabled.
// - Comparator cannot use converter input multiplexer while converter clock is off.
// - Converter enable survives sleep; re-enable makes next conversion extended.
// - Comparator is forced off in sleep modes other than idle and noise reduction.
// - Reference stays on in sleep while an enabled comparator uses it.
// - Reference is on only while brown-out, comparator or converter needs it.
// - Enabled brown-out detector and watchdog stay enabled in every sleep mode.
// - Input buffers off when io and converter clocks stop, except wake pins.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module scg_sleep_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	input wire logic sleepInstr,
	input wire logic extCrystalSel,
	input wire logic [3:0] extIrqReq,
	input wire logic [3:0] extIrqLevelMode,
	input wire logic powerStageIrq,
	input wire logic memReadyIrq,
	input wire logic convIrq,
	input wire logic wdtIrq,
	input wire logic otherIoIrq,
	input wire logic [1:0] timerRun,
	input wire logic convEnable,
	input wire logic convUsesRef,
	input wire logic convStart,
	input wire logic compEnable,
	input wire logic compUsesRef,
	input wire logic [2:0] brownoutLevelSetting,
	input wire logic wdtEnable,
	output logic coreClockEn,
	output logic programMemoryClockEn,
	output logic ioClockEn,
	output logic converterClockEn,
	output logic pllClockEn,
	output logic mainOscEn,
	output logic [7:0] periphClockEn,
	output logic [7:0] periphRegAccessEn,
	output logic compMuxAllow,
	output logic compForceOff,
	output logic convEnableOut,
	output logic convExtendedNext,
	output logic vrefEnable,
	output logic brownoutEnable,
	output logic wdtEnableOut,
	output logic inputBufferEn,
	output logic [3:0] irqPinBufferEn,
	output logic sleeping
);

	typedef struct packed {
		scg_pkg::scg_state_t st;
		logic [2:0] mode;
		logic sleepEn;
		logic [7:0] gate;
		logic [7:0] access;
		logic [7:0] rdata;
		logic asleep;
		logic coreClk;
		logic progClk;
		logic ioClk;
		logic convClk;
		logic pllClk;
		logic osc;
		logic [7:0] periphClk;
		logic compMux;
		logic compOff;
		logic convEn;
		logic convEnPrev;
		logic convExt;
		logic vref;
		logic bod;
		logic wdt;
		logic inBuf;
		logic [3:0] irqBuf;
	} scg_ctrl_t;

	scg_ctrl_t s_r;
	scg_ctrl_t s_nxt;
	logic wakeOk;
	logic wakeStart;
	logic wakeDone;
	logic [3:0] wakeCount;

	// Clock domains kept alive by a mode
	function automatic logic [3:0] domainsFor(input logic [2:0] mode);
		unique case (mode)
			scg_pkg::MODE_IDLE: domainsFor = scg_pkg::DOMS_IDLE;
			scg_pkg::MODE_NOISE: domainsFor = scg_pkg::DOMS_NOISE;
			scg_pkg::MODE_STANDBY: domainsFor = scg_pkg::DOMS_STANDBY;
			default: domainsFor = scg_pkg::DOMS_PDOWN;
		endcase
	endfunction

	// Only the four documented codes sleep; standby also needs a crystal
	function automatic logic modeLegal(input logic [2:0] mode, input logic crystal);
		unique case (mode)
			scg_pkg::MODE_IDLE,
			scg_pkg::MODE_NOISE,
			scg_pkg::MODE_PDOWN: modeLegal = 1'b1;
			scg_pkg::MODE_STANDBY: modeLegal = crystal;
			default: modeLegal = 1'b0;
		endcase
	endfunction

	// True when the mode is one of the two light modes
	function automatic logic lightMode(input logic [2:0] mode);
		lightMode = (mode == scg_pkg::MODE_IDLE) || (mode == scg_pkg::MODE_NOISE);
	endfunction

	// Wake decision for the mode held while asleep
	always_comb begin
		logic extWake;
		extWake = 1'b0;
		wakeOk = 1'b0;
		if (s_r.mode == scg_pkg::MODE_IDLE) begin
			extWake = |extIrqReq;
		end else begin
			extWake = |(extIrqReq & extIrqLevelMode);
		end
		unique case (s_r.mode)
			scg_pkg::MODE_IDLE: begin
				wakeOk = extWake | powerStageIrq | memReadyIrq | convIrq | wdtIrq | otherIoIrq;
			end
			scg_pkg::MODE_NOISE: begin
				wakeOk = extWake | powerStageIrq | memReadyIrq | convIrq | wdtIrq;
			end
			scg_pkg::MODE_PDOWN: begin
				wakeOk = extWake | powerStageIrq | wdtIrq;
			end
			scg_pkg::MODE_STANDBY: begin
				wakeOk = extWake | wdtIrq;
			end
			default: begin
				wakeOk = 1'b0;
			end
		endcase
	end

	assign wakeStart = (s_r.st == scg_pkg::ST_SLEEP) && wakeOk;
	assign wakeCount = (s_r.mode == scg_pkg::MODE_STANDBY) ? scg_pkg::STANDBY_WAKE_CYCLES
		: scg_pkg::OTHER_WAKE_CYCLES;

	// Wake delay counter
	scg_wake_delay u_delay (
		.clock(clock),
		.rst_n(rst_n),
		.start(wakeStart),
		.count(wakeCount),
		.done(wakeDone)
	);

	// Next state of the whole controller
	always_comb begin
		logic [3:0] dom;
		logic base;
		logic keep;
		dom = scg_pkg::DOMS_ACTIVE;
		base = 1'b0;
		keep = 1'b0;
		s_nxt = s_r;

		// Register writes; the CPU is halted in sleep, so mode cannot change under it
		if (regWrite) begin
			unique case (regAddr)
				scg_pkg::ADDR_GATE: begin
					s_nxt.gate = regWdata;
				end
				scg_pkg::ADDR_SLEEP_CTRL: begin
					s_nxt.sleepEn = regWdata[scg_pkg::SC_ENABLE_BIT];
					s_nxt.mode = regWdata[scg_pkg::SC_MODE_MSB:scg_pkg::SC_MODE_LSB];
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		s_nxt.rdata = '0;
		if (regRead) begin
			unique case (regAddr)
				scg_pkg::ADDR_GATE: begin
					s_nxt.rdata = s_r.gate;
				end
				scg_pkg::ADDR_SLEEP_CTRL: begin
					s_nxt.rdata[scg_pkg::SC_ENABLE_BIT] = s_r.sleepEn;
					s_nxt.rdata[scg_pkg::SC_MODE_MSB:scg_pkg::SC_MODE_LSB] = s_r.mode;
				end
				scg_pkg::ADDR_STATUS: begin
					s_nxt.rdata[scg_pkg::STS_ASLEEP_BIT] = s_r.asleep;
					s_nxt.rdata[scg_pkg::STS_WAKING_BIT] = (s_r.st == scg_pkg::ST_WAKING);
					s_nxt.rdata[scg_pkg::STS_CONV_EXT_BIT] = s_r.convExt;
					s_nxt.rdata[scg_pkg::STS_VREF_BIT] = s_r.vref;
					s_nxt.rdata[scg_pkg::STS_INBUF_BIT] = s_r.inBuf;
				end
				default: begin
				end
			endcase
		end

		// Sleep sequencing; reserved codes make the sleep instruction a no-op
		unique case (s_r.st)
			scg_pkg::ST_ACTIVE: begin
				if (sleepInstr && s_r.sleepEn && modeLegal(s_r.mode, extCrystalSel)) begin
					s_nxt.st = scg_pkg::ST_SLEEP;
				end
			end
			scg_pkg::ST_SLEEP: begin
				if (wakeOk) begin
					s_nxt.st = scg_pkg::ST_WAKING;
				end
			end
			scg_pkg::ST_WAKING: begin
				if (wakeDone) begin
					s_nxt.st = scg_pkg::ST_ACTIVE;
				end
			end
			default: begin
				s_nxt.st = scg_pkg::ST_ACTIVE;
			end
		endcase

		// Domain clocks; the sleep set holds until the wake delay ends
		s_nxt.asleep = (s_nxt.st != scg_pkg::ST_ACTIVE);
		if (s_nxt.asleep) begin
			dom = domainsFor(s_r.mode);
		end
		s_nxt.coreClk = !s_nxt.asleep;
		s_nxt.progClk = !s_nxt.asleep;
		s_nxt.ioClk = dom[scg_pkg::DOM_IO];
		s_nxt.convClk = dom[scg_pkg::DOM_CONV];
		s_nxt.pllClk = dom[scg_pkg::DOM_PLL];
		s_nxt.osc = dom[scg_pkg::DOM_OSC];

		// Peripheral clocks: gate bit on top of the domain clock
		for (int i = 0; i < 8; i++) begin
			base = (i == scg_pkg::GATE_CONVERTER) ? dom[scg_pkg::DOM_CONV] : dom[scg_pkg::DOM_IO];
			keep = !s_nxt.gate[i];
			if (i == scg_pkg::GATE_TIMER_ZERO) begin
				keep = keep || timerRun[0];
			end
			if (i == scg_pkg::GATE_TIMER_ONE) begin
				keep = keep || timerRun[1];
			end
			s_nxt.periphClk[i] = base && keep;
		end
		s_nxt.access = ~s_nxt.gate;

		// Analog helpers
		s_nxt.compMux = s_nxt.periphClk[scg_pkg::GATE_CONVERTER];
		s_nxt.compOff = s_nxt.asleep && !lightMode(s_r.mode);
		s_nxt.convEn = convEnable;
		s_nxt.convEnPrev = convEnable;
		// Set wins over the clear so a re-enable beside a start is not lost
		if (convStart) begin
			s_nxt.convExt = 1'b0;
		end
		if (convEnable && !s_r.convEnPrev) begin
			s_nxt.convExt = 1'b1;
		end
		s_nxt.bod = (brownoutLevelSetting != scg_pkg::BOD_DISABLED);
		s_nxt.wdt = wdtEnable;
		// Comparator reference need ignores the forced-off, so it survives sleep
		s_nxt.vref = s_nxt.bod || (compEnable && compUsesRef)
			|| (convEnable && convUsesRef);

		// Input buffers; level wake pins stay live
		s_nxt.inBuf = !(s_nxt.asleep && !dom[scg_pkg::DOM_IO] && !dom[scg_pkg::DOM_CONV]);
		s_nxt.irqBuf = s_nxt.inBuf ? scg_pkg::ALL_IRQ_PINS : extIrqLevelMode;
	end

	// State register; reset leaves every clock running
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= scg_pkg::ST_ACTIVE;
			s_r.gate <= scg_pkg::GATE_RESET;
			s_r.access <= ~scg_pkg::GATE_RESET;
			s_r.coreClk <= 1'b1;
			s_r.progClk <= 1'b1;
			s_r.ioClk <= 1'b1;
			s_r.convClk <= 1'b1;
			s_r.pllClk <= 1'b1;
			s_r.osc <= 1'b1;
			s_r.periphClk <= ~scg_pkg::GATE_RESET;
			s_r.compMux <= 1'b1;
			s_r.inBuf <= 1'b1;
			s_r.irqBuf <= scg_pkg::ALL_IRQ_PINS;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign regRdata = s_r.rdata;
	assign coreClockEn = s_r.coreClk;
	assign programMemoryClockEn = s_r.progClk;
	assign ioClockEn = s_r.ioClk;
	assign converterClockEn = s_r.convClk;
	assign pllClockEn = s_r.pllClk;
	assign mainOscEn = s_r.osc;
	assign periphClockEn = s_r.periphClk;
	assign periphRegAccessEn = s_r.access;
	assign compMuxAllow = s_r.compMux;
	assign compForceOff = s_r.compOff;
	assign convEnableOut = s_r.convEn;
	assign convExtendedNext = s_r.convExt;
	assign vrefEnable = s_r.vref;
	assign brownoutEnable = s_r.bod;
	assign wdtEnableOut = s_r.wdt;
	assign inputBufferEn = s_r.inBuf;
	assign irqPinBufferEn = s_r.irqBuf;
	assign sleeping = s_r.asleep;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_standby_wake;
		s_r.st == scg_pkg::ST_SLEEP && s_r.mode == scg_pkg::MODE_STANDBY && wakeOk;
	endsequence

	sequence s_six_dark;
		!coreClockEn [*6] ##1 coreClockEn;
	endsequence

	a_standby_wake_six: assert property (s_standby_wake |=> s_six_dark)
		else $error("standby wake did not resume after six cycles");

	a_core_clk_sleep: assert property (sleeping |-> !coreClockEn && !programMemoryClockEn)
		else $error("core clocks running while asleep");

	a_standby_osc_on: assert property (
		s_r.st == scg_pkg::ST_SLEEP && s_r.mode == scg_pkg::MODE_STANDBY
		|-> mainOscEn && !ioClockEn && !converterClockEn && !pllClockEn)
		else $error("standby clock set wrong");

	a_noise_domains: assert property (
		s_r.st == scg_pkg::ST_SLEEP && s_r.mode == scg_pkg::MODE_NOISE
		|-> !ioClockEn && converterClockEn && pllClockEn && mainOscEn)
		else $error("noise reduction clock set wrong");

	a_edge_no_wake: assert property (
		s_r.st == scg_pkg::ST_SLEEP && s_r.mode == scg_pkg::MODE_PDOWN
		&& !powerStageIrq && !wdtIrq && ((extIrqReq & extIrqLevelMode) == 4'h0)
		|=> sleeping && !coreClockEn)
		else $error("power-down woke from a disallowed source");

	a_gate_stops_clk: assert property (
		periphRegAccessEn[scg_pkg::GATE_SERIAL_PERIPH] == periphClockEn[scg_pkg::GATE_SERIAL_PERIPH]
		|| !ioClockEn)
		else $error("gated clock and register access disagree");

	a_ungate_restart: assert property (
		$fell(s_r.gate[scg_pkg::GATE_SERIAL_PORT_ZERO]) && ioClockEn
		|-> periphClockEn[scg_pkg::GATE_SERIAL_PORT_ZERO])
		else $error("clock did not restart on ungate");

	a_comp_mux_off: assert property (!converterClockEn |-> !compMuxAllow)
		else $error("comparator mux allowed with converter clock off");

	a_comp_auto_off: assert property (
		sleeping && !lightMode(s_r.mode) |-> compForceOff)
		else $error("comparator not forced off in deep sleep");

	a_vref_need: assert property (vrefEnable |-> $past(compEnable && compUsesRef)
		|| $past(convEnable && convUsesRef) || brownoutEnable)
		else $error("reference on with no user");

	a_inbuf_deep: assert property (
		sleeping && !ioClockEn && !converterClockEn |-> !inputBufferEn
		&& irqPinBufferEn == $past(extIrqLevelMode))
		else $error("input buffers not cut in deep sleep");

	a_gate_reset_zero: assert property ($past(!rst_n) |-> regRdata == 8'h00
		&& periphClockEn == 8'hff)
		else $error("gate register not clear after reset");

endmodule

// ---- include/scg_pkg.sv ----
// Constants shared by the sleep and clock gating controller and its wake delay counter.
// Assumes an 8-bit register port with a 4-bit word address.
package scg_pkg;

	// Sleep mode select codes
	localparam logic [2:0] MODE_IDLE = 3'h0;
	localparam logic [2:0] MODE_NOISE = 3'h1;
	localparam logic [2:0] MODE_PDOWN = 3'h2;
	localparam logic [2:0] MODE_STANDBY = 3'h6;

	// Controller states
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKING = 2'b10
	} scg_state_t;

	// Register addresses
	localparam logic [3:0] ADDR_GATE = 4'h0;
	localparam logic [3:0] ADDR_SLEEP_CTRL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;

	// Sleep control fields
	localparam int SC_ENABLE_BIT = 0;
	localparam int SC_MODE_LSB = 1;
	localparam int SC_MODE_MSB = 3;

	// Status fields
	localparam int STS_ASLEEP_BIT = 0;
	localparam int STS_WAKING_BIT = 1;
	localparam int STS_CONV_EXT_BIT = 2;
	localparam int STS_VREF_BIT = 3;
	localparam int STS_INBUF_BIT = 4;

	// Peripheral clock gate bit positions
	localparam int GATE_CONVERTER = 0;
	localparam int GATE_SERIAL_PORT_ZERO = 1;
	localparam int GATE_SERIAL_PERIPH = 2;
	localparam int GATE_TIMER_ZERO = 3;
	localparam int GATE_TIMER_ONE = 4;
	localparam int GATE_POWER_STAGE_0 = 5;
	localparam int GATE_POWER_STAGE_1 = 6;
	localparam int GATE_POWER_STAGE_2 = 7;
	localparam logic [7:0] GATE_RESET = 8'h00;

	// Clock domain vector {io, converter, pll, main source}
	localparam int DOM_IO = 3;
	localparam int DOM_CONV = 2;
	localparam int DOM_PLL = 1;
	localparam int DOM_OSC = 0;
	localparam logic [3:0] DOMS_ACTIVE = 4'hf;
	localparam logic [3:0] DOMS_IDLE = 4'hf;
	localparam logic [3:0] DOMS_NOISE = 4'h7;
	localparam logic [3:0] DOMS_PDOWN = 4'h0;
	localparam logic [3:0] DOMS_STANDBY = 4'h1;

	localparam logic [2:0] BOD_DISABLED = 3'h7;
	localparam logic [3:0] ALL_IRQ_PINS = 4'hf;

	// Wake delays in clock cycles
	localparam logic [3:0] STANDBY_WAKE_CYCLES = 4'h6;
	localparam logic [3:0] OTHER_WAKE_CYCLES = 4'h6;
	localparam logic [3:0] DELAY_LAST = 4'h1;
	localparam logic [3:0] DELAY_IDLE = 4'h0;

endpackage

// ---- core/scg_wake_delay.sv ----
// Down counter that times the gap from a wake event to resumed execution.
// Assumes start is a one-cycle pulse and count is at least one.
`timescale 1ns/1ps
module scg_wake_delay (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] count,
	output logic done
);

	typedef struct packed {
		logic [3:0] cnt;
	} scg_delay_t;

	scg_delay_t d_r;
	scg_delay_t d_nxt;

	// Load on start, then run down to idle
	always_comb begin
		d_nxt = d_r;
		if (start) begin
			d_nxt.cnt = count;
		end else if (d_r.cnt != scg_pkg::DELAY_IDLE) begin
			d_nxt.cnt = d_r.cnt - scg_pkg::DELAY_LAST;
		end
	end

	// Register the counter
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			d_r <= '0;
		end else begin
			d_r <= d_nxt;
		end
	end

	// Last counting cycle, so the caller resumes on the edge that empties it
	assign done = (d_r.cnt == scg_pkg::DELAY_LAST);

endmodule

// ---- test/scg_periph_model.sv ----
// Far side model: one gated peripheral whose state only moves on its own clock.
// Assumes the clock enable vector comes from the controller, sampled on the core clock.
`timescale 1ns/1ps
module scg_periph_model #(
	parameter int SLOT = 2
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] periphClockEn,
	output logic [15:0] periphState
);
	// Stopped clock holds the state exactly, so a resume continues from it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			periphState <= 16'h0000;
		end else if (periphClockEn[SLOT]) begin
			periphState <= periphState + 16'h0001;
		end
	end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the sleep and clock gating controller.
// Assumes a 40 MHz clock, synchronous active-low reset and the package register map.
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic sleepInstr = 1'b0;
	logic extCrystalSel = 1'b1;
	logic [3:0] extIrqLevelMode = 4'h5;
	logic [6:0] irqSrc = 7'h00;
	logic [1:0] timerRun = 2'h0;
	logic convEnable = 1'b0;
	logic convUsesRef = 1'b0;
	logic convStart = 1'b0;
	logic compEnable = 1'b0;
	logic compUsesRef = 1'b0;
	logic [2:0] brownoutLevelSetting = 3'h7;
	logic wdtEnable = 1'b0;
	logic [7:0] regRdata, periphClockEn, periphRegAccessEn;
	logic coreClockEn, programMemoryClockEn, ioClockEn, converterClockEn, pllClockEn, mainOscEn;
	logic compMuxAllow, compForceOff, convEnableOut, convExtendedNext, vrefEnable;
	logic brownoutEnable, wdtEnableOut, inputBufferEn, sleeping;
	logic [3:0] irqPinBufferEn;
	logic [15:0] periphState;
	int failures = 0;
	int checks = 0;

	// Wake sources: [0] watchdog [1] power stage [2] converter [3] memory [4] other [6:5] lines
	scg_sleep_ctrl DUT (.clock, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.sleepInstr, .extCrystalSel, .extIrqReq({2'h0, irqSrc[6:5]}), .extIrqLevelMode,
		.powerStageIrq(irqSrc[1]), .memReadyIrq(irqSrc[3]), .convIrq(irqSrc[2]),
		.wdtIrq(irqSrc[0]), .otherIoIrq(irqSrc[4]), .timerRun, .convEnable, .convUsesRef,
		.convStart, .compEnable, .compUsesRef, .brownoutLevelSetting, .wdtEnable, .coreClockEn,
		.programMemoryClockEn, .ioClockEn, .converterClockEn, .pllClockEn, .mainOscEn,
		.periphClockEn, .periphRegAccessEn, .compMuxAllow, .compForceOff, .convEnableOut,
		.convExtendedNext, .vrefEnable, .brownoutEnable, .wdtEnableOut, .inputBufferEn,
		.irqPinBufferEn, .sleeping);

	scg_periph_model #(.SLOT(2)) periphModel (.clock, .rst_n, .periphClockEn, .periphState);

	// Free-running core clock
	always #12.5 clock = ~clock;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Settle just past an edge so registered outputs are stable
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask

	task automatic enter(input logic [2:0] mode);
		wr(scg_pkg::ADDR_SLEEP_CTRL, {4'h0, mode, 1'b1});
		@(posedge clock);
		sleepInstr <= 1'b1;
		@(posedge clock);
		sleepInstr <= 1'b0;
		cyc(1);
	endtask

	// Counts edges from the sampling edge of the source to the core clock restart
	task automatic wake(input logic [6:0] src, output int n);
		@(posedge clock);
		irqSrc <= src;
		cyc(1);
		n = 0;
		while (n < 30 && coreClockEn !== 1'b1) begin
			cyc(1);
			n++;
		end
		@(posedge clock);
		irqSrc <= 7'h00;
		if (n == 30) begin
			failures++;
			end_sim();
		end
	endtask

	task automatic reset_test();
		logic [7:0] d;
		rd(scg_pkg::ADDR_GATE, d);
		check("gateReset", d, 8'h00);
		check("clockReset", periphClockEn, 8'hff);
		rd(scg_pkg::ADDR_STATUS, d);
		check("statusReset", d, 8'h10);
		$display("test reset done");
	endtask

	task automatic gate_test();
		logic [7:0] v, d;
		for (int i = 0; i < 8; i++) begin
			v = 8'h01 << i;
			wr(scg_pkg::ADDR_GATE, v);
			rd(scg_pkg::ADDR_GATE, d);
			check("gateRead", d, v);
			check("clockEn", periphClockEn, 8'(~v));
			check("accessEn", periphRegAccessEn, 8'(~v));
			check("muxAllow", compMuxAllow, !v[0]);
		end
		@(posedge clock);
		timerRun <= 2'h3;
		wr(scg_pkg::ADDR_GATE, 8'h18);
		cyc(2);
		check("timerClock", periphClockEn[4:3], 2'h3);
		check("timerAccess", periphRegAccessEn[4:3], 2'h0);
		wr(4'h7, 8'hff);
		rd(4'h7, d);
		check("unmapped", d, 8'h00);
		rd(scg_pkg::ADDR_GATE, d);
		check("gateKept", d, 8'h18);
		@(posedge clock);
		timerRun <= 2'h0;
		$display("test gate done");
	endtask

	task automatic freeze_test();
		logic [15:0] s;
		int n;
		wr(scg_pkg::ADDR_GATE, 8'h04);
		cyc(2);
		s = periphState;
		cyc(5);
		check("frozen", periphState, s);
		enter(scg_pkg::MODE_IDLE);
		check("idleGate", periphClockEn, 8'hfb);
		wake(7'h10, n);
		wr(scg_pkg::ADDR_GATE, 8'h00);
		cyc(5);
		check("resumed", periphState > s && periphState < s + 16'h0008, 1'b1);
		$display("test freeze done");
	endtask

	// Every reserved code, and standby without a crystal, must leave the core running
	task automatic reserved_test();
		logic [7:0] d;
		@(posedge clock);
		extCrystalSel <= 1'b0;
		enter(scg_pkg::MODE_STANDBY);
		check("noCrystal", sleeping, 1'b0);
		for (int c = 3; c < 8; c++) begin
			if (c != 6) begin
				enter(3'(c));
				check("reserved", sleeping, 1'b0);
			end
		end
		// Last loop pass left mode 111 with sleep enable set
		rd(scg_pkg::ADDR_SLEEP_CTRL, d);
		check("modeRead", d, 8'h0f);
		@(posedge clock);
		extCrystalSel <= 1'b1;
		$display("test reserved done");
	endtask

	task automatic ref_test();
		int n;
		check("refOff", vrefEnable, 1'b0);
		@(posedge clock);
		compEnable <= 1'b1;
		compUsesRef <= 1'b1;
		enter(scg_pkg::MODE_PDOWN);
		check("refSleep", {vrefEnable, compForceOff}, 2'h3);
		wake(7'h01, n);
		compEnable <= 1'b0;
		convEnable <= 1'b1;
		convUsesRef <= 1'b1;
		cyc(3);
		check("convRef", {vrefEnable, convExtendedNext}, 2'h3);
		@(posedge clock);
		convStart <= 1'b1;
		@(posedge clock);
		convStart <= 1'b0;
		cyc(1);
		check("extendedDone", convExtendedNext, 1'b0);
		@(posedge clock);
		convEnable <= 1'b0;
		convUsesRef <= 1'b0;
		brownoutLevelSetting <= 3'h2;
		cyc(3);
		check("bodRef", {vrefEnable, brownoutEnable}, 2'h3);
		$display("test reference done");
	endtask

	task automatic sleep_case(input logic [2:0] mode, input logic [3:0] doms,
		input logic [6:0] deny, input logic [6:0] src);
		logic deep;
		int n;
		deep = (doms[3:2] == 2'h0);
		enter(mode);
		check("sleeping", sleeping, 1'b1);
		check("coreClocks", {coreClockEn, programMemoryClockEn}, 2'h0);
		check("domains", {ioClockEn, converterClockEn, pllClockEn, mainOscEn}, doms);
		check("compForceOff", compForceOff, deep);
		check("inputBufferEn", inputBufferEn, !deep);
		if (deep) check("pinBuffers", irqPinBufferEn, extIrqLevelMode);
		check("keptOn", {brownoutEnable, wdtEnableOut, convEnableOut}, 3'h7);
		@(posedge clock);
		irqSrc <= deny;
		cyc(10);
		check("denied", sleeping, 1'b1);
		wake(src, n);
		check("wakeDelay", n, 6);
		check("awake", {sleeping, coreClockEn, inputBufferEn}, 3'h3);
		$display("test sleep mode %0d done", mode);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		reset_test();
		gate_test();
		freeze_test();
		reserved_test();
		ref_test();
		@(posedge clock);
		wdtEnable <= 1'b1;
		convEnable <= 1'b1;
		sleep_case(scg_pkg::MODE_IDLE, 4'hf, 7'h00, 7'h10);
		sleep_case(scg_pkg::MODE_NOISE, 4'h7, 7'h50, 7'h08);
		sleep_case(scg_pkg::MODE_PDOWN, 4'h0, 7'h4c, 7'h02);
		sleep_case(scg_pkg::MODE_STANDBY, 4'h1, 7'h46, 7'h20);
		end_sim();
	end
endmodule
